// ==== inc/sdct_params.svh ====
/*
  Constants for the two-bank 16-bit synchronous DRAM command timing core:
  command codes, mode word fields, address fields and cycle counts.
  Assumes a single 20 MHz clock and a controller that keeps its own spacing.
*/
`ifndef SDCT_PARAMS_SVH
`define SDCT_PARAMS_SVH

// {cs_n, ras_n, cas_n, we_n}
`define SDCT_CMD_MODE  4'h0
`define SDCT_CMD_REF   4'h1
`define SDCT_CMD_PRE   4'h2
`define SDCT_CMD_ACT   4'h3
`define SDCT_CMD_WR    4'h4
`define SDCT_CMD_RD    4'h5
`define SDCT_CMD_STOP  4'h6

// address fields
`define SDCT_BANK_BIT  11
`define SDCT_AP_BIT    10
`define SDCT_ROW_W     11
`define SDCT_COL_W     8

// mode word fields
`define SDCT_BL_LSB    0
`define SDCT_BT_BIT    3
`define SDCT_CL_LSB    4
`define SDCT_WBM_BIT   9
`define SDCT_MODE_RST  12'h030
`define SDCT_BL_FULL   3'h7

// cycle figures
`define SDCT_CL3       3'h3
`define SDCT_PQL_CYC   2'h2
`define SDCT_DPL_CYC   2'h1

`endif

// ==== inc/sdct_pkg.sv ====
/*
  Types shared by the DRAM timing core: the decoded command.
  Assumes sdct_params.svh supplies the raw encodings.
*/
package sdct_pkg;

  typedef enum {
    SDCT_NOP, SDCT_MODE, SDCT_REF, SDCT_PRE, SDCT_ACT, SDCT_WR, SDCT_RD, SDCT_STOP
  } sdct_cmd_t;

endpackage : sdct_pkg

// ==== hdl/sdct_bank.sv ====
/*
  One bank's row state: open flag and open row address.
  Assumes the caller decodes activate and precharge for this bank.
*/
`timescale 1ns/100ps
`include "sdct_params.svh"

module sdct_bank (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic                    act,
  input  wire logic                    pre,
  input  wire logic [`SDCT_ROW_W-1:0]  row_in,
  output logic                         open_r,
  output logic      [`SDCT_ROW_W-1:0]  row_r
);
  import sdct_pkg::*;

  logic                    open_nxt;
  logic [`SDCT_ROW_W-1:0]  row_nxt;

  // activate opens a row, precharge closes it
  always_comb begin
    open_nxt = open_r;
    row_nxt  = row_r;
    if (act) begin
      open_nxt = 1'b1;
      row_nxt  = row_in;
    end else if (pre) begin
      open_nxt = 1'b0;
    end
  end

  // row state registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      open_r <= 1'b0;
      row_r  <= {`SDCT_ROW_W{1'b0}};
    end else begin
      open_r <= open_nxt;
      row_r  <= row_nxt;
    end
  end

endmodule : sdct_bank

// ==== hdl/sdct_core.sv ====
/*
  Memory-side timing core of a two-bank 16-bit synchronous DRAM: command
  decode, mode word, burst engine, read latency pipe, masks, burst stop,
  precharge truncation and auto-precharge, over a full-size storage array.
  Assumes commands arrive synchronous to clk and that the controller keeps
  all spacing minimums; refresh needs no action in this storage.
*/
`timescale 1ns/100ps
`include "sdct_params.svh"

module sdct_core (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         cke,
  input  wire logic         cs_n,
  input  wire logic         ras_n,
  input  wire logic         cas_n,
  input  wire logic         we_n,
  input  wire logic [11:0]  addr,
  input  wire logic [1:0]   dqm,
  input  wire logic [15:0]  dq_in,
  output logic      [15:0]  dq_out,
  output logic      [1:0]   dq_oe,
  output logic      [1:0]   bank_open
);
  import sdct_pkg::*;

  localparam int MEM_AW = 1 + `SDCT_ROW_W + `SDCT_COL_W;

  sdct_cmd_t   cmd;
  logic [11:0] mode_r, mode_nxt;
  logic        cl3;
  logic [15:0] mem [0:(1<<MEM_AW)-1];
  logic [`SDCT_ROW_W-1:0] row [0:1];
  logic [1:0]  act_b, pre_b;

  // burst engine state
  logic        rd_act_r, rd_act_nxt, wr_act_r, wr_act_nxt;
  logic [7:0]  beat_r, beat_nxt, col0_r, col0_nxt;
  logic        bbank_r, bbank_nxt, ap_r, ap_nxt;
  logic        iss, iss_wr, iss_bank, iss_ap, last, kill, full;
  logic [7:0]  iss_beat, iss_col, lmask, ofs;
  logic [MEM_AW-1:0] idx;
  logic [1:0]  wr_lane;

  // auto-precharge state
  logic        ap_pend_r, ap_pend_nxt, ap_bank_r, ap_bank_nxt;
  logic [1:0]  ap_cnt_r, ap_cnt_nxt, apd;
  logic        ap_go, fire_now, fire_bank;

  // read pipe state
  logic        s0_v_r, s0_v_nxt, s1_v_r, s1_v_nxt;
  logic [15:0] s0_d_r, s0_d_nxt, s1_d_r, s1_d_nxt, dq_out_nxt;
  logic [1:0]  dq_oe_nxt, dqm_d1_r, dqm_d1_nxt;

  // command decode; low clock enable suspends everything
  always_comb begin
    cmd = SDCT_NOP;
    if (cke) begin
      case ({cs_n, ras_n, cas_n, we_n})
        `SDCT_CMD_MODE: cmd = SDCT_MODE;
        `SDCT_CMD_REF:  cmd = SDCT_REF;
        `SDCT_CMD_PRE:  cmd = SDCT_PRE;
        `SDCT_CMD_ACT:  cmd = SDCT_ACT;
        `SDCT_CMD_WR:   cmd = SDCT_WR;
        `SDCT_CMD_RD:   cmd = SDCT_RD;
        `SDCT_CMD_STOP: cmd = SDCT_STOP;
        default:        cmd = SDCT_NOP;
      endcase
    end
  end

  // mode word
  assign mode_nxt = (cmd == SDCT_MODE) ? addr : mode_r;
  assign cl3      = (mode_r[`SDCT_CL_LSB +: 3] == `SDCT_CL3);

  // burst engine: one column per cycle, a new column command restarts it
  always_comb begin
    rd_act_nxt = rd_act_r;
    wr_act_nxt = wr_act_r;
    beat_nxt   = beat_r;
    col0_nxt   = col0_r;
    bbank_nxt  = bbank_r;
    ap_nxt     = ap_r;
    iss        = 1'b0;
    iss_wr     = wr_act_r;
    iss_bank   = bbank_r;
    iss_ap     = ap_r;
    iss_beat   = beat_r;
    iss_col    = col0_r;
    kill = (cmd == SDCT_STOP) || ((cmd == SDCT_PRE)
           && (addr[`SDCT_AP_BIT] || (addr[`SDCT_BANK_BIT] == bbank_r)));
    if (cmd == SDCT_RD || cmd == SDCT_WR) begin
      iss       = 1'b1;
      iss_wr    = (cmd == SDCT_WR);
      iss_bank  = addr[`SDCT_BANK_BIT];
      iss_ap    = addr[`SDCT_AP_BIT];
      iss_beat  = 8'h00;
      iss_col   = addr[`SDCT_COL_W-1:0];
      col0_nxt  = addr[`SDCT_COL_W-1:0];
      bbank_nxt = addr[`SDCT_BANK_BIT];
      ap_nxt    = addr[`SDCT_AP_BIT];
    end else if (cke && (rd_act_r || wr_act_r) && !kill) begin
      iss = 1'b1;
    end
    // burst length; single-write mode shortens writes to one beat
    full  = (mode_r[`SDCT_BL_LSB +: 3] == `SDCT_BL_FULL);
    lmask = full ? 8'hff : (8'h01 << mode_r[`SDCT_BL_LSB +: 2]) - 8'h01;
    if (iss_wr && mode_r[`SDCT_WBM_BIT]) begin
      full  = 1'b0;
      lmask = 8'h00;
    end
    // sequential or interleaved column order inside the burst window
    ofs = mode_r[`SDCT_BT_BIT] ? (iss_col ^ iss_beat) : (iss_col + iss_beat);
    iss_col = (iss_col & ~lmask) | (ofs & lmask);
    last = !full && (iss_beat == lmask);
    if (cke) begin
      rd_act_nxt = iss && !iss_wr && !last;
      wr_act_nxt = iss && iss_wr && !last;
      beat_nxt   = iss_beat + 8'h01;
    end
  end

  assign idx = {iss_bank, row[iss_bank], iss_col};

  // write lanes: a set mask bit blocks its byte in the same cycle
  assign wr_lane = {2{iss && iss_wr}} & ~dqm;

  // auto-precharge: reads start it before the last output, writes after
  always_comb begin
    apd = iss_wr ? `SDCT_DPL_CYC
        : (cl3 ? 2'(3'(`SDCT_CL3) - 3'h1 - 3'(`SDCT_PQL_CYC)) : 2'h0);
    ap_go       = iss && last && iss_ap;
    fire_now    = (ap_go && apd == 2'h0) || (cke && ap_pend_r && ap_cnt_r == 2'h0);
    fire_bank   = (ap_pend_r && ap_cnt_r == 2'h0) ? ap_bank_r : iss_bank;
    ap_pend_nxt = ap_pend_r;
    ap_cnt_nxt  = ap_cnt_r;
    ap_bank_nxt = ap_bank_r;
    if (ap_go && apd != 2'h0) begin
      ap_pend_nxt = 1'b1;
      ap_cnt_nxt  = apd - 2'h1;
      ap_bank_nxt = iss_bank;
    end else if (cke && ap_pend_r && ap_cnt_r == 2'h0) begin
      ap_pend_nxt = 1'b0;
    end else if (cke && ap_pend_r) begin
      ap_cnt_nxt = ap_cnt_r - 2'h1;
    end
  end

  // bank row state, one instance per bank
  genvar b;
  for (b = 0; b < 2; b++) begin : g_bank
    assign act_b[b] = (cmd == SDCT_ACT) && (addr[`SDCT_BANK_BIT] == 1'(b));
    assign pre_b[b] = ((cmd == SDCT_PRE)
                      && (addr[`SDCT_AP_BIT] || addr[`SDCT_BANK_BIT] == 1'(b)))
                      || (fire_now && fire_bank == 1'(b));
    sdct_bank u_bank (
      .clk    (clk),
      .resetn (resetn),
      .act    (act_b[b]),
      .pre    (pre_b[b]),
      .row_in (addr[`SDCT_ROW_W-1:0]),
      .open_r (bank_open[b]),
      .row_r  (row[b])
    );
  end

  // read pipe: output lags the command by the column latency
  always_comb begin
    s0_v_nxt   = s0_v_r;
    s0_d_nxt   = s0_d_r;
    s1_v_nxt   = s1_v_r;
    s1_d_nxt   = s1_d_r;
    dq_out_nxt = dq_out;
    dq_oe_nxt  = dq_oe;
    dqm_d1_nxt = dqm_d1_r;
    if (cke) begin
      s0_v_nxt   = iss && !iss_wr;
      s0_d_nxt   = mem[idx];
      s1_v_nxt   = s0_v_r;
      s1_d_nxt   = s0_d_r;
      dq_out_nxt = cl3 ? s1_d_r : s0_d_r;
      dq_oe_nxt  = {2{cl3 ? s1_v_r : s0_v_r}} & ~dqm_d1_r;
      dqm_d1_nxt = dqm;
    end
  end

  // storage writes, byte lanes
  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (wr_lane[i]) begin
        mem[idx][i*8 +: 8] <= dq_in[i*8 +: 8];
      end
    end
  end

  // control registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_r    <= `SDCT_MODE_RST;
      rd_act_r  <= 1'b0;
      wr_act_r  <= 1'b0;
      beat_r    <= 8'h00;
      col0_r    <= 8'h00;
      bbank_r   <= 1'b0;
      ap_r      <= 1'b0;
      ap_pend_r <= 1'b0;
      ap_cnt_r  <= 2'h0;
      ap_bank_r <= 1'b0;
      s0_v_r    <= 1'b0;
      s0_d_r    <= 16'h0000;
      s1_v_r    <= 1'b0;
      s1_d_r    <= 16'h0000;
      dq_out    <= 16'h0000;
      dq_oe     <= 2'h0;
      dqm_d1_r  <= 2'h0;
    end else begin
      mode_r    <= mode_nxt;
      rd_act_r  <= rd_act_nxt;
      wr_act_r  <= wr_act_nxt;
      beat_r    <= beat_nxt;
      col0_r    <= col0_nxt;
      bbank_r   <= bbank_nxt;
      ap_r      <= ap_nxt;
      ap_pend_r <= ap_pend_nxt;
      ap_cnt_r  <= ap_cnt_nxt;
      ap_bank_r <= ap_bank_nxt;
      s0_v_r    <= s0_v_nxt;
      s0_d_r    <= s0_d_nxt;
      s1_v_r    <= s1_v_nxt;
      s1_d_r    <= s1_d_nxt;
      dq_out    <= dq_out_nxt;
      dq_oe     <= dq_oe_nxt;
      dqm_d1_r  <= dqm_d1_nxt;
    end
  end

  // checks on the timing relations
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_col_back2back: assert property ((cmd == SDCT_RD) |-> iss && !iss_wr && iss_beat == 8'h00)
    else $error("column command not taken at once");
  a_stop_float: assert property ((cmd == SDCT_STOP && rd_act_r && cl3
      && !(rd_act_nxt)) ##1 (cmd != SDCT_RD && cmd != SDCT_WR)[*2] |-> ##1 dq_oe == 2'h0)
    else $error("read data not floated three cycles after stop");
  a_stop_wr_block: assert property ((cmd == SDCT_STOP && wr_act_r) |-> wr_lane == 2'h0)
    else $error("write data taken in stop cycle");
  a_pre_float: assert property ((cmd == SDCT_PRE && kill && rd_act_r && cl3)
      ##1 (cmd != SDCT_RD && cmd != SDCT_WR)[*2] |-> ##1 dq_oe == 2'h0)
    else $error("read data not floated three cycles after precharge");
  a_pre_wr_block: assert property ((cmd == SDCT_PRE && kill && wr_act_r) |-> wr_lane == 2'h0)
    else $error("write data taken in precharge cycle");
  a_rd_ap_start: assert property ((iss && !iss_wr && last && iss_ap && cl3) |-> fire_now
      ##1 !bank_open[$past(iss_bank)])
    else $error("read auto-precharge not started on time");
  a_mask_read: assert property ((dq_oe[0] && $past(cke, 1) && $past(cke, 2)) |-> !$past(dqm[0], 2))
    else $error("masked read lane driven");
  a_mask_write: assert property ((iss && iss_wr && dqm[1]) |-> !wr_lane[1] && $stable(mode_r))
    else $error("masked write lane stored");

  c_read_burst: cover property ((cmd == SDCT_RD) ##1 rd_act_r [*3]);
  c_write_burst: cover property ((cmd == SDCT_WR) ##1 wr_act_r [*3]);
  c_stop_read: cover property (rd_act_r && cmd == SDCT_STOP);
  c_auto_pre: cover property (ap_go ##[0:3] fire_now);

endmodule : sdct_core

// ==== bench/sdct_ctrl_model.sv ====
/*
  Controller stand-in for the DRAM timing core: drives command, mask and data pins.
  Assumes its tasks are called at a falling clock edge.
*/
`timescale 1ns/100ps
`include "sdct_params.svh"

module sdct_ctrl_model (
  input  wire logic        clk,
  output logic             cke,
  output logic             cs_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n,
  output logic      [11:0] addr,
  output logic      [1:0]  dqm,
  output logic      [15:0] dq_in
);
  // quiet bus at time zero, no command pending
  initial begin
    cke = 1'b1;
    {cs_n, ras_n, cas_n, we_n} = 4'h7;
    addr = 12'h000;
    dqm = 2'h0;
    dq_in = 16'h0000;
  end

  // one command held over one rising edge
  task automatic cmd(input logic [3:0] c, input logic [11:0] a, input logic [1:0] m,
                     input logic [15:0] d);
    {cs_n, ras_n, cas_n, we_n} = c;
    addr = a;
    dqm = m;
    dq_in = d;
    @(negedge clk);
  endtask : cmd

  // no command; released data lines toggle so stale words never match
  task automatic nop(input int n);
    repeat (n) begin
      {cs_n, ras_n, cas_n, we_n} = 4'h7;
      dqm = 2'h0;
      dq_in = ~dq_in;
      @(negedge clk);
    end
  endtask : nop

  // open a row, then hold off column and other-bank commands
  task automatic act(input logic [11:0] a);
    cmd(`SDCT_CMD_ACT, a, 2'h0, 16'h0000);
    nop(2);
  endtask : act

  // close a bank after write recovery, then wait out the precharge
  task automatic pre(input logic [11:0] a);
    nop(1);
    cmd(`SDCT_CMD_PRE, a, 2'h0, 16'h0000);
    nop(2);
  endtask : pre

  // auto-refresh with both banks closed, then sit out the row cycle
  task automatic refresh;
    cmd(`SDCT_CMD_REF, 12'h000, 2'h0, 16'h0000);
    nop(8);
  endtask : refresh

  // clock suspend for n edges, then one quiet edge before the next command
  task automatic pause(input int n);
    cke = 1'b0;
    nop(n);
    cke = 1'b1;
    nop(1);
  endtask : pause

  // load the mode word while both banks are closed
  task automatic mode(input logic [11:0] a);
    cmd(`SDCT_CMD_MODE, a, 2'h0, 16'h0000);
    nop(2);
  endtask : mode
endmodule : sdct_ctrl_model

// ==== bench/tb_sdct_core.sv ====
/*
  Self-checking bench for the DRAM timing core, driven through the controller stand-in.
  Assumes the mode word after reset gives read latency 3 and single-word bursts.
*/
`timescale 1ns/100ps
`include "sdct_params.svh"

`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module tb_sdct_core;
  logic        clk;
  logic        resetn;
  logic        cke;
  logic        cs_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic [11:0] addr;
  logic [1:0]  dqm;
  logic [1:0]  dq_oe;
  logic [1:0]  bank_open;
  logic [15:0] dq_in;
  logic [15:0] dq_out;
  logic [15:0] w [4];
  int          fails = 0;
  int          total_checks = 0;

  sdct_core sdct_core_inst (.clk(clk), .resetn(resetn), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr), .dqm(dqm), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .bank_open(bank_open));

  sdct_ctrl_model sdct_ctrl_model_inst (.clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .addr(addr), .dqm(dqm), .dq_in(dq_in));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // shorthands for the stand-in
  task automatic issue(input logic [3:0] c, input logic [11:0] a, input logic [1:0] m,
                       input logic [15:0] d);
    sdct_ctrl_model_inst.cmd(c, a, m, d);
  endtask : issue

  task automatic idle(input int n);
    sdct_ctrl_model_inst.nop(n);
  endtask : idle

  // four-word read, each word taken as it stands
  task automatic rd4(input logic [11:0] a, output logic [15:0] q [4]);
    issue(`SDCT_CMD_RD, a, 2'h0, 16'h0000);
    idle(1);
    for (int k = 0; k < 4; k++) begin
      idle(1);
      q[k] = dq_out;
    end
  endtask : rd4

  // back-to-back writes then back-to-back reads
  task automatic t_b2b;
    sdct_ctrl_model_inst.act(12'h001);
    issue(`SDCT_CMD_WR, 12'h005, 2'h0, 16'h1234);
    issue(`SDCT_CMD_WR, 12'h006, 2'h0, 16'habcd);
    issue(`SDCT_CMD_RD, 12'h005, 2'h0, 16'h0000);
    issue(`SDCT_CMD_RD, 12'h006, 2'h0, 16'h0000);
    idle(1);
    `CHK("rd0", 16'h1234, dq_out)
    `CHK("oe0", 2'h3, dq_oe)
    idle(1);
    `CHK("rd1", 16'habcd, dq_out)
    idle(1);
    `CHK("oe_end", 2'h0, dq_oe)
    $display("t_b2b done");
  endtask : t_b2b

  // masked write lane keeps old byte; masked read lane floats two edges on
  task automatic t_mask;
    issue(`SDCT_CMD_WR, 12'h005, 2'h1, 16'h00ff);
    issue(`SDCT_CMD_RD, 12'h005, 2'h0, 16'h0000);
    issue(4'h7, 12'h000, 2'h2, 16'h0000);
    idle(1);
    `CHK("mask_oe", 2'h1, dq_oe)
    `CHK("mask_lo", 8'h34, dq_out[7:0])
    sdct_ctrl_model_inst.pre(12'h400);
    $display("t_mask done");
  endtask : t_mask

  // burst of four cut short by stop or precharge, read and write
  task automatic t_trunc(input logic [3:0] c);
    sdct_ctrl_model_inst.mode(12'h032);
    sdct_ctrl_model_inst.act(12'h802);
    issue(`SDCT_CMD_WR, 12'h800, 2'h0, 16'h1111);
    issue(4'h7, 12'h000, 2'h0, 16'h2222);
    issue(4'h7, 12'h000, 2'h0, 16'h3333);
    issue(4'h7, 12'h000, 2'h0, 16'h4444);
    idle(1);
    issue(`SDCT_CMD_RD, 12'h800, 2'h0, 16'h0000);
    issue(c, 12'h800, 2'h0, 16'h0000);
    idle(1);
    `CHK("cut_w0", 16'h1111, dq_out)
    `CHK("cut_oe", 2'h3, dq_oe)
    idle(1);
    `CHK("cut_hiz", 2'h0, dq_oe)
    if (c == `SDCT_CMD_PRE) `CHK("pre_shut", 1'b0, bank_open[1])
    idle(2);
    if (c == `SDCT_CMD_PRE) sdct_ctrl_model_inst.act(12'h802);
    issue(`SDCT_CMD_WR, 12'h800, 2'h0, 16'haaaa);
    issue(c, 12'h800, 2'h0, 16'hbbbb);
    idle(2);
    if (c == `SDCT_CMD_PRE) sdct_ctrl_model_inst.act(12'h802);
    rd4(12'h800, w);
    `CHK("wcut_w0", 16'haaaa, w[0])
    `CHK("wcut_w1", 16'h2222, w[1])
    `CHK("wcut_w3", 16'h4444, w[3])
    sdct_ctrl_model_inst.pre(12'h400);
    $display("t_trunc done");
  endtask : t_trunc

  // clock suspend freezes a read burst; write auto-precharge closes the bank
  task automatic t_susp;
    sdct_ctrl_model_inst.act(12'h802);
    issue(`SDCT_CMD_RD, 12'h800, 2'h0, 16'h0000);
    idle(2);
    `CHK("susp_w0", 16'haaaa, dq_out)
    sdct_ctrl_model_inst.pause(2);
    `CHK("susp_w1", 16'h2222, dq_out)
    `CHK("susp_oe", 2'h3, dq_oe)
    idle(3);
    `CHK("susp_end", 2'h0, dq_oe)
    issue(`SDCT_CMD_WR, 12'hc04, 2'h0, 16'h5555);
    idle(3);
    `CHK("wap_open", 1'b1, bank_open[1])
    idle(1);
    `CHK("wap_shut", 1'b0, bank_open[1])
    idle(2);
    $display("t_susp done");
  endtask : t_susp

  // read with auto-precharge closes the bank at the last issued beat
  task automatic t_ap;
    sdct_ctrl_model_inst.act(12'h803);
    issue(`SDCT_CMD_RD, 12'hc00, 2'h0, 16'h0000);
    idle(2);
    `CHK("ap_open", 1'b1, bank_open[1])
    idle(1);
    `CHK("ap_shut", 1'b0, bank_open[1])
    idle(4);
    $display("t_ap done");
  endtask : t_ap

  // counts, verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // cut a hang short at 4000 cycles, well beyond the power-up wait and tests
  initial begin
    #(4000 * 50);
    fails++;
    tally_and_finish();
  end

  // reset for five cycles, then the scenarios
  initial begin
    resetn = 1'b0;
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    idle(2000);
    sdct_ctrl_model_inst.pre(12'h400);
    repeat (8) sdct_ctrl_model_inst.refresh();
    sdct_ctrl_model_inst.mode(12'h030);
    t_b2b();
    t_mask();
    t_trunc(`SDCT_CMD_STOP);
    t_trunc(`SDCT_CMD_PRE);
    t_susp();
    t_ap();
    tally_and_finish();
  end
endmodule : tb_sdct_core
